// *** core/jsvc_pkg.sv ***
package jsvc_pkg;
  // instruction codes and scan widths
  localparam int           IR_W     = 5;
  localparam int           DR_W     = 34;
  localparam logic [4:0]   IR_BLOCK = 5'h12;
  localparam logic [4:0]   IR_ABORT = 5'h13;
  localparam logic [4:0]   IR_RATIO = 5'h17;
  localparam logic [4:0]   IR_RSTC  = 5'h0C;
  localparam logic [4:0]   IR_WIPE  = 5'h0F;
  localparam logic [4:0]   IR_HALT  = 5'h1C;
  localparam logic [4:0]   IR_BYP   = 5'h1F;
  localparam logic [5:0]   LEN_BLK  = 6'h22;
  localparam logic [5:0]   LEN_RAT  = 6'h10;
  localparam logic [5:0]   LEN_ONE  = 6'h01;
  // apb register offsets
  localparam logic [7:0]   OFS_STAT = 8'h00;
  localparam logic [7:0]   OFS_CTRL = 8'h04;
  localparam logic [7:0]   OFS_ADLO = 8'h08;
  localparam logic [7:0]   OFS_ADHI = 8'h0C;
  // field positions
  localparam int           CTRL_NVM = 0;
  localparam int           CTRL_SEC = 1;
  localparam int           ADHI_SZ  = 4;
  localparam int           ADHI_RD  = 6;
  localparam int           STAT_DOM = 8;
  // reset values
  localparam logic         NVM_RST  = 1'b1;
  localparam logic [35:0]  ADDR_RST = 36'h0_0000_0000;
  localparam logic [1:0]   SIZE_RST = 2'h2;

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, DR_SEL   = 16'h0004,
    DR_CAP    = 16'h0008, DR_SHIFT = 16'h0010, DR_EX1   = 16'h0020,
    DR_PAUSE  = 16'h0040, DR_EX2   = 16'h0080, DR_UPD   = 16'h0100,
    IR_SEL    = 16'h0200, IR_CAP   = 16'h0400, IR_SHIFT = 16'h0800,
    IR_EX1    = 16'h1000, IR_PAUSE = 16'h2000, IR_EX2   = 16'h4000,
    IR_UPD    = 16'h8000
  } jsvc_tap_e;

  // service bus request and answer
  typedef struct packed {
    logic [35:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
  } jsvc_sab_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } jsvc_sab_rsp_s;
endpackage : jsvc_pkg

// *** core/jsvc_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for pins from outside the clock domain
module jsvc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : jsvc_sync

// *** core/jsvc_core.sv ***
`timescale 1ns/1ps
module jsvc_core
  import jsvc_pkg::*;
#(
  parameter int NDOM = 5
) (
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  wire logic          TCK,
  input  wire logic          TMS,
  input  wire logic          TDI,
  output logic               TDO,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output jsvc_sab_req_s      SAB_CMD,
  output logic               SAB_REQ,
  output logic               SAB_ABORT,
  input  wire jsvc_sab_rsp_s SAB_RSP,
  output logic [NDOM-1:0]    RST_DOMAIN,
  output logic               CPU_HALT,
  output logic               DEV_RESET,
  output logic               NVM_ERASE,
  input  wire logic          NVM_DONE
);
  if (NDOM < 1 || NDOM > 8) begin : g_chk
    $error("NDOM must lie between 1 and 8");
  end

  logic [2:0]     pins_s;
  logic           tck_q_r;
  logic           tck_rise;
  logic           tck_fall;
  jsvc_tap_e      tap_r;
  jsvc_tap_e      tap_nxt;
  logic [4:0]     ir_r;
  logic [4:0]     ir_sh_r;
  logic [4:0]     ir_cap;
  logic [DR_W-1:0] dr_sh_r;
  logic [DR_W-1:0] dr_nxt;
  logic [DR_W-1:0] dr_cap;
  logic [5:0]     dr_len;
  logic           upd_dr;
  logic           upd_ir;
  logic           cap_dr;
  logic           cap_ir;
  logic [35:0]    addr_r;
  logic [1:0]     size_r;
  logic           rd_r;
  logic [31:0]    wdata_r;
  logic [31:0]    rdata_r;
  logic           busy_r;
  logic           err_r;
  logic           abort_r;
  logic           launch;
  logic [35:0]    inc;
  logic [15:0]    cnt_r;
  logic [NDOM-1:0] dom_r;
  logic           halt_r;
  logic           devrst_r;
  logic           ers_busy_r;
  logic           ers_pulse_r;
  logic           sec_r;
  logic           nvm_r;
  logic [31:0]    prdata_r;
  logic           apb_wr;
  logic           mapped;

  jsvc_sync #(
    .W (3)
  ) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({TCK, TMS, TDI}),
    .q   (pins_s)
  );

  // tck edges found from the synchronised copy only
  always_ff @(posedge CLK) begin
    if (SYS_RST) tck_q_r <= 1'b0;
    else         tck_q_r <= pins_s[2];
  end
  assign tck_rise = pins_s[2] & ~tck_q_r;
  assign tck_fall = ~pins_s[2] & tck_q_r;

  // tap controller next state
  always_comb begin
    unique case (tap_r)
      TAP_RESET: tap_nxt = pins_s[1] ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:  tap_nxt = pins_s[1] ? DR_SEL : TAP_IDLE;
      DR_SEL:    tap_nxt = pins_s[1] ? IR_SEL : DR_CAP;
      DR_CAP:    tap_nxt = pins_s[1] ? DR_EX1 : DR_SHIFT;
      DR_SHIFT:  tap_nxt = pins_s[1] ? DR_EX1 : DR_SHIFT;
      DR_EX1:    tap_nxt = pins_s[1] ? DR_UPD : DR_PAUSE;
      DR_PAUSE:  tap_nxt = pins_s[1] ? DR_EX2 : DR_PAUSE;
      DR_EX2:    tap_nxt = pins_s[1] ? DR_UPD : DR_SHIFT;
      DR_UPD:    tap_nxt = pins_s[1] ? DR_SEL : TAP_IDLE;
      IR_SEL:    tap_nxt = pins_s[1] ? TAP_RESET : IR_CAP;
      IR_CAP:    tap_nxt = pins_s[1] ? IR_EX1 : IR_SHIFT;
      IR_SHIFT:  tap_nxt = pins_s[1] ? IR_EX1 : IR_SHIFT;
      IR_EX1:    tap_nxt = pins_s[1] ? IR_UPD : IR_PAUSE;
      IR_PAUSE:  tap_nxt = pins_s[1] ? IR_EX2 : IR_PAUSE;
      IR_EX2:    tap_nxt = pins_s[1] ? IR_UPD : IR_SHIFT;
      IR_UPD:    tap_nxt = pins_s[1] ? DR_SEL : TAP_IDLE;
      default:   tap_nxt = TAP_RESET; // upset one-hot code
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST)       tap_r <= TAP_RESET;
    else if (tck_rise) tap_r <= tap_nxt;
  end

  // actions happen as tck rises out of the named state
  assign cap_dr = tck_rise && tap_r == DR_CAP;
  assign cap_ir = tck_rise && tap_r == IR_CAP;
  assign upd_dr = tck_rise && tap_r == DR_UPD;
  assign upd_ir = tck_rise && tap_r == IR_UPD;

  // instruction capture: protection, error, busy, then 01; wipe puts erase busy there, rstc and halt zeros
  always_comb begin
    unique case (ir_r)
      IR_WIPE:          ir_cap = {sec_r, 1'b0, ers_busy_r, 2'b01};
      IR_RSTC, IR_HALT: ir_cap = {sec_r, 4'b0001};
      default:          ir_cap = {sec_r, err_r, busy_r, 2'b01};
    endcase
  end

  // instruction shift and update
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ir_r    <= IR_BYP;
      ir_sh_r <= '0;
    end else if (tck_rise) begin
      if (tap_r == TAP_RESET) ir_r <= IR_BYP;
      if (tap_r == IR_CAP)    ir_sh_r <= ir_cap;
      if (tap_r == IR_SHIFT)  ir_sh_r <= {pins_s[0], ir_sh_r[4:1]};
      if (tap_r == IR_UPD)    ir_r <= ir_sh_r;
    end
  end

  // data register length follows the instruction
  always_comb begin
    unique case (ir_r)
      IR_BLOCK: dr_len = LEN_BLK;
      IR_RATIO: dr_len = LEN_RAT;
      IR_RSTC:  dr_len = 6'(NDOM);
      default:  dr_len = LEN_ONE;  // abort, wipe, halt and bypass
    endcase
  end

  // capture values; abort and wipe read zero
  always_comb begin
    dr_cap = '0;
    unique case (ir_r)
      IR_BLOCK: dr_cap = {err_r, busy_r, rdata_r};
      IR_RATIO: dr_cap[0] = cnt_r != 16'h0000;
      IR_RSTC:  dr_cap[NDOM-1:0] = dom_r;
      IR_HALT:  dr_cap[0] = halt_r;
      default:  dr_cap = '0;
    endcase
  end

  // tdi enters at the top of the active length, lsb leaves first
  always_comb begin
    dr_nxt = dr_sh_r >> 1;
    dr_nxt[dr_len - 6'h01] = pins_s[0];
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST)                      dr_sh_r <= '0;
    else if (cap_dr)                  dr_sh_r <= dr_cap;
    else if (tck_rise && tap_r == DR_SHIFT) dr_sh_r <= dr_nxt;
  end

  // tdo changes on the falling tck so the host samples it stable
  always_ff @(posedge CLK) begin
    if (SYS_RST) TDO <= 1'b0;
    else if (tck_fall && tap_r == IR_SHIFT) TDO <= ir_sh_r[0];
    else if (tck_fall && tap_r == DR_SHIFT) TDO <= dr_sh_r[0];
  end

  // service bus launch when not busy: ir load prefetches a read, each update repeats
  assign inc = 36'h0_0000_0001 << size_r;
  assign launch = !busy_r &&
    ((upd_dr && ir_r == IR_BLOCK) ||
     (upd_ir && ir_sh_r == IR_BLOCK && rd_r));
  assign apb_wr = PSEL && PENABLE && PWRITE;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      addr_r  <= ADDR_RST;
      size_r  <= SIZE_RST;
      rd_r    <= 1'b1;
      wdata_r <= '0;
      rdata_r <= '0;
      busy_r  <= 1'b0;
      err_r   <= 1'b0;
    end else if (launch) begin
      addr_r  <= addr_r + inc;
      wdata_r <= dr_sh_r[31:0];
      busy_r  <= 1'b1;
      err_r   <= 1'b0;
    end else if (busy_r && SAB_RSP.ack) begin
      busy_r  <= 1'b0;
      err_r   <= SAB_RSP.err || abort_r;
      if (rd_r) rdata_r <= SAB_RSP.rdata;
    end else if (apb_wr && !busy_r) begin
      // seeding point for an access started elsewhere
      if (PADDR == OFS_ADLO) addr_r[31:0] <= PWDATA;
      if (PADDR == OFS_ADHI) begin
        addr_r[35:32] <= PWDATA[3:0];
        size_r        <= PWDATA[ADHI_SZ +: 2];
        rd_r          <= PWDATA[ADHI_RD];
      end
    end
  end

  // abort stays raised until the bus finally answers
  always_ff @(posedge CLK) begin
    if (SYS_RST) abort_r <= 1'b0;
    else if (busy_r && SAB_RSP.ack) abort_r <= 1'b0;
    else if (upd_ir && ir_sh_r == IR_ABORT && busy_r) abort_r <= 1'b1;
  end

  assign SAB_REQ   = busy_r;
  assign SAB_ABORT = abort_r;
  assign SAB_CMD   = '{addr: addr_r, size: size_r, write: ~rd_r,
                       wdata: wdata_r};

  // clock ratio probe runs on the system clock
  always_ff @(posedge CLK) begin
    if (SYS_RST) cnt_r <= '0;
    else if (upd_dr && ir_r == IR_RATIO) cnt_r <= dr_sh_r[15:0];
    else if (cnt_r != 16'h0000) cnt_r <= cnt_r - 16'h0001;
  end

  // reset domains and cpu halt; halt writes also pulse a device reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dom_r    <= '0;
      halt_r   <= 1'b0;
      devrst_r <= 1'b0;
    end else begin
      devrst_r <= 1'b0;
      if (upd_dr && ir_r == IR_RSTC) dom_r <= dr_sh_r[NDOM-1:0];
      if (upd_dr && ir_r == IR_HALT) begin
        halt_r   <= dr_sh_r[0];
        devrst_r <= 1'b1;
      end
    end
  end

  assign RST_DOMAIN = dom_r;
  assign CPU_HALT   = halt_r;
  assign DEV_RESET  = devrst_r;

  // erase starts as the instruction is selected, not on a data scan
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ers_busy_r  <= 1'b0;
      ers_pulse_r <= 1'b0;
      sec_r       <= 1'b0;
    end else begin
      ers_pulse_r <= 1'b0;
      if (apb_wr && PADDR == OFS_CTRL && PWDATA[CTRL_SEC]) sec_r <= 1'b1;
      if (upd_ir && ir_sh_r == IR_WIPE && !ers_busy_r) begin
        if (nvm_r) begin
          ers_busy_r  <= 1'b1;
          ers_pulse_r <= 1'b1;
        end else begin
          sec_r <= 1'b0;
        end
      end
      // erase end wins over a security set in the same cycle
      if (ers_busy_r && NVM_DONE) begin
        ers_busy_r <= 1'b0;
        sec_r      <= 1'b0;
      end
    end
  end

  assign NVM_ERASE = ers_pulse_r;

  // apb: read data registered in setup, no wait states
  assign mapped  = PADDR == OFS_STAT || PADDR == OFS_CTRL ||
                   PADDR == OFS_ADLO || PADDR == OFS_ADHI;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = prdata_r;

  always_ff @(posedge CLK) begin
    if (SYS_RST) nvm_r <= NVM_RST;
    else if (apb_wr && PADDR == OFS_CTRL) nvm_r <= PWDATA[CTRL_NVM];
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) prdata_r <= '0;
    else if (PSEL && !PENABLE) begin
      prdata_r <= '0;
      unique case (PADDR)
        OFS_STAT: begin
          prdata_r[5:0] <= {cnt_r != 16'h0000, halt_r, ers_busy_r,
                            sec_r, err_r, busy_r};
          prdata_r[STAT_DOM +: NDOM] <= dom_r;
        end
        OFS_CTRL: prdata_r[1:0] <= {sec_r, nvm_r};
        OFS_ADLO: prdata_r <= addr_r[31:0];
        OFS_ADHI: prdata_r[6:0] <= {rd_r, size_r, addr_r[35:32]};
        default:  prdata_r <= '0;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_blk_upd;
    upd_dr && ir_r == IR_BLOCK && !busy_r;
  endsequence
  sequence s_done;
    busy_r && SAB_RSP.ack;
  endsequence

  blk_step_a: assert property (s_blk_upd |=>
    addr_r == $past(addr_r) + $past(inc) && SAB_REQ)
    else $error("block address did not advance by size");
  blk_repeat_a: assert property (s_blk_upd |=>
    SAB_CMD.write == $past(!rd_r) && $stable(size_r))
    else $error("block access changed direction or size");
  busy_hold_a: assert property (SAB_REQ && !SAB_RSP.ack |=>
    SAB_REQ && $stable(SAB_CMD))
    else $error("bus request dropped before answer");
  abort_err_a: assert property ((SAB_ABORT and s_done) |=>
    err_r && !SAB_ABORT && !SAB_REQ)
    else $error("aborted access not reported as error");
  ratio_cnt_a: assert property (cnt_r != 16'h0000 &&
    !(upd_dr && ir_r == IR_RATIO) |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("ratio counter did not count down");
  dom_hold_a: assert property (upd_dr && ir_r == IR_RSTC |=>
    RST_DOMAIN == $past(dr_sh_r[NDOM-1:0]) ##1 $stable(RST_DOMAIN))
    else $error("reset domains not loaded from scan");
  halt_wr_a: assert property (upd_dr && ir_r == IR_HALT |=>
    DEV_RESET && CPU_HALT == $past(dr_sh_r[0]) ##1 !DEV_RESET)
    else $error("halt write did not reset device once");
  halt_cap_a: assert property (cap_dr && ir_r == IR_HALT |=>
    dr_sh_r[0] == CPU_HALT)
    else $error("halt capture does not show cpu state");
  wipe_go_a: assert property (upd_ir && ir_sh_r == IR_WIPE &&
    nvm_r && !ers_busy_r |=> NVM_ERASE && ers_busy_r)
    else $error("erase did not start at instruction select");
  wipe_cap_a: assert property (cap_ir && ir_r == IR_WIPE |=>
    ir_sh_r[2] == $past(ers_busy_r) && ir_sh_r[1:0] == 2'b01)
    else $error("instruction capture lacks erase busy");
  wipe_sec_a: assert property (ers_busy_r && NVM_DONE |=>
    !sec_r && !ers_busy_r)
    else $error("erase end left security set");
endmodule : jsvc_core

// *** tb/jsvc_far.sv ***
`timescale 1ns/1ps
// far side: service bus slave and the memory erase engine
module jsvc_far
  import jsvc_pkg::*;
#(
  parameter logic [31:0] MIX = 32'h5A5A_0000,
  parameter int          ERS = 600
) (
  input  wire logic          clk,
  input  wire logic          stall,
  input  wire jsvc_sab_req_s cmd,
  input  wire logic          req,
  input  wire logic          abort,
  output jsvc_sab_rsp_s      rsp,
  output jsvc_sab_req_s      last,
  input  wire logic          erase,
  output logic               done
);
  int wait_r = 0;
  int ers_r  = 0;

  initial begin
    rsp  = '0;
    done = 1'b0;
  end

  // answer 3 cycles in, or at once on abort; data toggles outside an
  // answer so a stale word can never pass for a fresh one
  always @(posedge clk) begin
    rsp.ack   <= 1'b0;
    rsp.err   <= 1'b0;
    rsp.rdata <= ~rsp.rdata;
    wait_r    <= req ? wait_r + 1 : 0;
    if (req && !rsp.ack && ((!stall && wait_r == 3) || abort)) begin
      rsp.ack   <= 1'b1;
      rsp.err   <= abort;
      rsp.rdata <= cmd.addr[31:0] ^ MIX;
      last      <= cmd;
    end
  end

  // erase runs ERS cycles, then a one-cycle done
  always @(posedge clk) begin
    done  <= (ers_r == 1);
    ers_r <= erase ? ERS : (ers_r > 0 ? ers_r - 1 : 0);
  end
endmodule : jsvc_far

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// self-checking bench for the test port service block
module testbench;
  import jsvc_pkg::*;
  localparam logic [31:0] MIX = 32'h5A5A_0000;
  logic          clk     = 1'b0;
  logic          rst     = 1'b1;
  logic          tck     = 1'b0;
  logic          tms     = 1'b1;
  logic          tdi     = 1'b0;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [7:0]    paddr   = 8'h00;
  logic [31:0]   pwdata  = 32'h0000_0000;
  logic          stall   = 1'b0;
  logic          tdo, pready, pslverr, sab_req, sab_abort, cpu_halt;
  logic          dev_reset, nvm_erase, nvm_done, so, se;
  logic [31:0]   prdata, rd;
  logic [35:0]   dout;
  logic [4:0]    rst_dom;
  jsvc_sab_req_s sab_cmd, last;
  jsvc_sab_rsp_s sab_rsp;
  int            n_fail      = 0;
  int            check_count = 0;
  int            cycles      = 0;
  int            resets      = 0;
  int            erases      = 0;

  jsvc_core #(.NDOM(5)) jsvc_core_i (
    .CLK(clk), .SYS_RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAB_CMD(sab_cmd), .SAB_REQ(sab_req), .SAB_ABORT(sab_abort),
    .SAB_RSP(sab_rsp), .RST_DOMAIN(rst_dom), .CPU_HALT(cpu_halt),
    .DEV_RESET(dev_reset), .NVM_ERASE(nvm_erase), .NVM_DONE(nvm_done));
  jsvc_far #(.MIX(MIX), .ERS(600)) jsvc_far_i (
    .clk(clk), .stall(stall), .cmd(sab_cmd), .req(sab_req),
    .abort(sab_abort), .rsp(sab_rsp), .last(last), .erase(nvm_erase),
    .done(nvm_done));

  // 50 MHz system clock
  initial begin
    forever #10 clk = ~clk;
  end

  // pulse counters and the hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (dev_reset === 1'b1) resets <= resets + 1;
    if (nvm_erase === 1'b1) erases <= erases + 1;
    if (cycles == 60000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // the bus answer lands a few clocks after update; wait for idle first
  task automatic sab_wait;
    do begin
      @(posedge clk);
    end while (sab_req !== 1'b0);
  endtask : sab_wait

  // one test clock; wide halves because the pins are resynchronised
  task automatic tick(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (6) @(posedge clk);
    so = tdo;
    tck <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : tick

  // idle to shift, n bits lsb first, through update back to idle
  task automatic scan(input logic ir, input int n, input logic [35:0] din);
    int i;
    tick(1'b1, 1'b0);
    if (ir) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = so;
    end
    tick(1'b1, 1'b0);  // update
    tick(1'b0, 1'b0);
  endtask : scan

  // register reset values and an unmapped address
  task automatic t_regs;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(36'(rd), 36'(NVM_RST));
    apb(1'b0, OFS_ADHI, 32'h0);
    chk(36'(rd), 36'((1 << ADHI_RD) | (SIZE_RST << ADHI_SZ)));
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd), 36'h0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk(36'(se), 36'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(36'({se, rd}), 36'h1_0000_0000);
    $display("test regs done");
  endtask : t_regs

  // block writes at sizes 0 to 2, then a prefetching word read
  task automatic t_block;
    int s;
    int k;
    logic [35:0] a;
    for (s = 0; s < 3; s++) begin
      apb(1'b1, OFS_ADLO, 32'h0000_1000);  // seeded first
      apb(1'b1, OFS_ADHI, 32'(s) << ADHI_SZ);
      scan(1'b1, IR_W, 36'(IR_BLOCK));
      a = 36'h1000;
      for (k = 0; k < 2; k++) begin
        a = a + (36'h1 << s);
        scan(1'b0, DR_W, 36'hC0DE_0000 + 36'(s));
        sab_wait();
        chk(last.addr, a);
        chk(36'({last.write, last.size}), 36'(4 + s));
        chk(36'(last.wdata), 36'hC0DE_0000 + 36'(s));
      end
    end
    apb(1'b1, OFS_ADLO, 32'h0000_2000);
    apb(1'b1, OFS_ADHI, 32'h0000_0060);
    scan(1'b1, IR_W, 36'(IR_BLOCK));
    for (k = 1; k < 3; k++) begin
      scan(1'b0, DR_W, 36'h0);
      sab_wait();
      chk(dout, 36'(32'h2000 + 4 * k) ^ 36'(MIX));
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[1:0]), 36'h0);
    $display("test block done");
  endtask : t_block

  // stalled write cut short, then a fresh write accepted
  task automatic t_abort;
    stall <= 1'b1;
    apb(1'b1, OFS_ADHI, 32'h0000_0020);
    scan(1'b1, IR_W, 36'(IR_BLOCK));
    scan(1'b0, DR_W, 36'h0_1111_1111);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[1:0]), 36'h1);
    // an update while busy must not launch or touch the pending command
    scan(1'b0, DR_W, 36'h0_3333_3333);
    chk(36'(dout[33:32]), 36'h1);
    chk(36'(sab_cmd.wdata), 36'h1111_1111);
    scan(1'b1, IR_W, 36'(IR_ABORT));
    scan(1'b0, 1, 36'h1);
    chk(36'(dout[0]), 36'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[1:0]), 36'h2);
    stall <= 1'b0;
    scan(1'b1, IR_W, 36'(IR_BLOCK));
    scan(1'b0, DR_W, 36'h0_2222_2222);
    sab_wait();
    chk(36'(last.wdata), 36'h2222_2222);
    $display("test abort done");
  endtask : t_abort

  // countdown of 1024 system clocks
  task automatic t_ratio;
    scan(1'b1, IR_W, 36'(IR_RATIO));
    scan(1'b0, 16, 36'h0400);
    repeat (900) @(posedge clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[5]), 36'h1);
    repeat (200) @(posedge clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[5]), 36'h0);
    scan(1'b0, 16, 36'h0);
    chk(36'(dout[0]), 36'h0);
    $display("test ratio done");
  endtask : t_ratio

  // reset domains held, read back and released
  task automatic t_rstc;
    scan(1'b1, IR_W, 36'(IR_RSTC));
    scan(1'b0, 5, 36'h15);
    chk(36'(rst_dom), 36'h15);
    scan(1'b0, 5, 36'h0A);
    chk(36'(dout[4:0]), 36'h15);
    chk(36'(rst_dom), 36'h0A);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[STAT_DOM +: 5]), 36'h0A);
    scan(1'b0, 5, 36'h0);
    chk(36'(rst_dom), 36'h0);
    $display("test domains done");
  endtask : t_rstc

  // halt and release, each with a device reset pulse
  task automatic t_halt;
    int r0;
    r0 = resets;
    scan(1'b1, IR_W, 36'(IR_HALT));
    scan(1'b0, 1, 36'h1);
    chk(36'(cpu_halt), 36'h1);
    scan(1'b0, 1, 36'h0);
    chk(36'(dout[0]), 36'h1);
    chk(36'(cpu_halt), 36'h0);
    chk(36'(resets - r0), 36'h2);
    $display("test halt done");
  endtask : t_halt

  // full erase with security set, then the part without memory
  task automatic t_wipe;
    int n;
    int e0;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    scan(1'b1, IR_W, 36'(IR_HALT));
    scan(1'b0, 1, 36'h1);
    repeat (10) tick(1'b0, 1'b0);
    e0 = erases;
    scan(1'b1, IR_W, 36'(IR_WIPE));
    chk(36'(erases - e0), 36'h1);
    scan(1'b0, 1, 36'h1);
    chk(36'(dout[0]), 36'h0);
    scan(1'b1, IR_W, 36'(IR_WIPE));
    chk(36'(dout[4:0]), 36'h15);
    n = 0;
    do begin
      scan(1'b1, IR_W, 36'(IR_WIPE));
      n++;
    end while (dout[4:0] !== 5'h01 && n < 20);
    chk(36'(dout[4:0]), 36'h01);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(36'(rd[2]), 36'h0);
    scan(1'b1, IR_W, 36'(IR_HALT));
    scan(1'b0, 1, 36'h0);
    repeat (60) tick(1'b0, 1'b0);  // ten and more
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    scan(1'b1, IR_W, 36'(IR_WIPE));
    scan(1'b1, IR_W, 36'(IR_WIPE));
    chk(36'(dout[4:0]), 36'h01);
    $display("test wipe done");
  endtask : t_wipe

  // main sequence
  initial begin
    dout = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    tick(1'b0, 1'b0);
    t_regs();
    t_block();
    t_abort();
    t_ratio();
    t_rstc();
    t_halt();
    t_wipe();
    close_out();
  end
endmodule : testbench
